// ---- dv/board_model.sv ----
`timescale 1ns/1ps
module board_model (
  input wire logic hold_low,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  output logic reset_pin_in
);
  // pull-up unless board or device pulls low; board holds as told
  assign reset_pin_in = !(hold_low || (reset_pin_oe && !reset_pin_out));
endmodule : board_model

// ---- dv/rst_props.sv ----
`timescale 1ns/1ps
module rst_props import rst_strap_pkg::*; (
  input wire logic clk_sys, reset_n, reset_pin_in, reset_pin_out, reset_pin_oe,
  input wire logic watchdog_reset, power_monitor_reset, idle_mode, power_down_mode,
  input wire logic wake_request, program_strobe_pin, external_code_select_pin,
  input wire logic program_strobe_oe, core_reset, port_reset_async,
  input wire rst_strap_pkg::boot_strap_t boot_strap
);
  logic [6:0] low_run;
  // saturates so a very long hold never wraps back to a short count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) low_run <= 7'h00;
    else low_run <= reset_pin_in ? 7'h00 : low_run + {6'h00, low_run != 7'h7F};
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_qualify_reset: assert property (low_run == 7'h40 |-> core_reset)
    else $error("core reset missing after long low");
  a_no_early: assert property ($rose(core_reset) |->
    low_run == 7'h40 || $past(watchdog_reset || power_monitor_reset)) else $error("early reset");
  a_port_async: assert property (!reset_pin_in |-> port_reset_async)
    else $error("ports not forced");
  a_wake_sleep: assert property (!reset_pin_in && (idle_mode || power_down_mode)
    |=> wake_request) else $error("no wake");
  a_drive_min: assert property ((watchdog_reset || power_monitor_reset)
    |=> reset_pin_oe [*6] ##1 reset_pin_oe [*6]) else $error("drive too short");
  a_open_drain: assert property (reset_pin_oe |-> !reset_pin_out && core_reset)
    else $error("pin driven high");
  a_strap_take: assert property ($rose(core_reset) |-> boot_strap ==
    {~$past(program_strobe_pin), ~$past(external_code_select_pin), boot_vector}
    && !program_strobe_oe) else $error("strap wrong");
  a_strap_frozen: assert property (!core_reset |-> $stable(boot_strap))
    else $error("strap moved");
endmodule : rst_props

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import rst_strap_pkg::*;
  logic clk_sys = 0, reset_n = 0, hold_low = 0, watchdog_reset = 0, power_monitor_reset = 0;
  logic idle_mode = 0, power_down_mode = 0, program_strobe_pin = 1, external_code_select_pin = 1;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, wake_request, program_strobe_oe;
  logic core_reset, port_reset_async;
  boot_strap_t boot_strap, exp_bs;
  logic [23:0] q[$];
  int errors = 0, comparisons = 0, cyc = 0;
  initial forever #10 clk_sys = ~clk_sys;
  board_model u_board(.*);
  reset_pin_and_boot_strap u_dut(.*);
  task automatic check(input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch outputs expected %h seen %h", exp, seen);
    end
  endtask : check
  function automatic void note(input logic c, o, w, a);
    q.push_back({c, o, w, a, 2'h0, exp_bs});
  endfunction : note
  always @(negedge clk_sys) if (q.size() > 0) check({core_reset, reset_pin_oe, wake_request,
    port_reset_async, reset_pin_out, program_strobe_oe, boot_strap},
    q.pop_front());
  // 63 lows must not reset, so count exactly and let straps change meanwhile
  task automatic pulse(input int n);
    logic s1, s2;
    s1 = 1'($urandom);
    s2 = 1'($urandom);
    @(posedge clk_sys);
    hold_low <= 1'b1;
    program_strobe_pin <= s1;
    external_code_select_pin <= s2;
    idle_mode <= 1'($urandom);
    power_down_mode <= 1'($urandom);
    repeat (n) @(posedge clk_sys);
    hold_low <= 1'b0;
    if (n >= 64) exp_bs = '{~s1, ~s2, boot_vector};
    note(n >= 64, 1'b0, idle_mode | power_down_mode, 1'b1);
    repeat (4) @(posedge clk_sys);
    $display("pulse %0d done", n);
  endtask : pulse
  task automatic source(input logic which);
    @(posedge clk_sys);
    watchdog_reset <= !which;
    power_monitor_reset <= which;
    exp_bs = '{~program_strobe_pin, ~external_code_select_pin, boot_vector};
    for (int k = 1; k <= 13; k++) begin
      @(posedge clk_sys);
      watchdog_reset <= 1'b0;
      power_monitor_reset <= 1'b0;
      note(1'b1, k <= 12, (idle_mode | power_down_mode) && k >= 2, 1'b1);
    end
    repeat (4) @(posedge clk_sys);
    $display("source %0d done", which);
  endtask : source
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(261));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pulse(64);
    pulse(63);
    source(1'b0);
    source(1'b1);
    pulse(64);
    give_verdict();
  end
endmodule : tb_top
bind reset_pin_and_boot_strap rst_props u_props(.*);

// ---- rtl/reset_pin_and_boot_strap.sv ----
`timescale 1ns/1ps
module reset_pin_and_boot_strap (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // internal reset sources, one-cycle pulses
  input wire logic watchdog_reset,
  input wire logic power_monitor_reset,
  // power modes
  input wire logic idle_mode,
  input wire logic power_down_mode,
  output logic wake_request,
  // strap pins
  input wire logic program_strobe_pin,
  input wire logic external_code_select_pin,
  output logic program_strobe_oe,
  // results
  output logic core_reset,
  output logic port_reset_async,
  output rst_strap_pkg::boot_strap_t boot_strap
);
  import rst_strap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  // release lands on a clock edge, assertion still acts at once
  logic rst_sync_a, rst_sync_b;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_a <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_sync_a <= 1'b1;
      rst_sync_b <= rst_sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port reset is set by a low pin with no clock, so a dead oscillator still resets ports; release waits for a clock edge
  always_ff @(posedge clk_sys or negedge reset_pin_in) begin
    if (!reset_pin_in) begin
      port_reset_async <= 1'b1;
    end else begin
      port_reset_async <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // qualification of a low reset pin
  // only consecutive low samples count toward a reset

  logic [cnt_w-1:0] qual_cnt;
  logic [cnt_w-1:0] next_qual_cnt;
  logic qual_done;

  // any high sample throws the count away, so glitches never reset the core
  always_comb begin
    next_qual_cnt = qual_cnt;
    if (!reset_pin_in) begin
      if (qual_cnt != qual_count) begin
        next_qual_cnt = qual_cnt + count_one;
      end
    end else begin
      next_qual_cnt = count_zero;
    end
  end

  // saturates at the threshold: a long hold cannot wrap and drop reset
  assign qual_done = (next_qual_cnt == qual_count);

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      qual_cnt <= count_zero;
    end else begin
      qual_cnt <= next_qual_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal reset sources pull the pin low
  // the pin is open drain, so the board may stretch the low further

  logic [cnt_w-1:0] drive_cnt;
  logic [cnt_w-1:0] next_drive_cnt;
  logic source_hit;
  logic oe_q;
  logic next_oe;

  assign source_hit = watchdog_reset || power_monitor_reset;

  // every pulse reloads the full count, so back-to-back sources stretch the drive
  always_comb begin
    next_drive_cnt = drive_cnt;
    if (source_hit) begin
      next_drive_cnt = drive_count;
    end else if (drive_cnt != count_zero) begin
      next_drive_cnt = drive_cnt - count_one;
    end
    next_oe = (next_drive_cnt != count_zero);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      drive_cnt <= count_zero;
      oe_q <= 1'h0;
    end else begin
      drive_cnt <= next_drive_cnt;
      oe_q <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core reset
  // held from power-up until the pin is first seen high

  logic core_reset_q;
  logic next_core_reset;

  // our own drive reads back as a low pin, so the core is held until it ends
  always_comb begin
    next_core_reset = core_reset_q;
    if (qual_done) begin
      next_core_reset = 1'h1;
    end else if (reset_pin_in) begin
      next_core_reset = 1'h0;
    end
    if (source_hit) begin
      next_core_reset = 1'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      core_reset_q <= 1'h1;
    end else begin
      core_reset_q <= next_core_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake from idle or power-down
  // a level, not a pulse: the power control drops the mode itself

  logic wake_q;
  logic next_wake;
  logic sleeping;

  assign sleeping = idle_mode || power_down_mode;

  // no qualification here: even a short low pulse ends a sleep
  always_comb begin
    next_wake = 1'h0;
    if (!reset_pin_in && sleeping) begin
      next_wake = 1'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= next_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot straps
  // last sample before release wins; later pin moves are ignored

  boot_strap_t strap_q;
  boot_strap_t next_strap;

  // pins are followed for as long as reset lasts, then frozen for the run
  always_comb begin
    next_strap = strap_q;
    if (next_core_reset) begin
      next_strap.in_system_programming_mode = !program_strobe_pin;
      next_strap.external_fetch = !external_code_select_pin;
      next_strap.start_address = boot_vector;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_q <= strap_reset;
    end else begin
      strap_q <= next_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  // strobe pin stays an input: this block never drives it

  logic next_pin_out;
  logic next_strobe_oe;

  // open drain: the pin is only ever pulled low or released, never driven high
  always_comb begin
    next_pin_out = 1'h0;
    next_strobe_oe = 1'h0;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      program_strobe_oe <= 1'h0;
      reset_pin_out <= 1'h0;
    end else begin
      program_strobe_oe <= next_strobe_oe;
      reset_pin_out <= next_pin_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered copies onto the ports
  assign reset_pin_oe = oe_q;
  assign core_reset = core_reset_q;
  assign wake_request = wake_q;
  assign boot_strap = strap_q;
endmodule : reset_pin_and_boot_strap

// ---- rtl/rst_strap_pkg.sv ----
// How it works
// - reset taken after pin held low 64 consecutive clocks; board holds it that long
// - pin below low threshold forces port pins to reset state asynchronously
// - reset pin assertion exits idle or power-down back to normal operation
// - watchdog or power-monitor reset drives reset pin low at least 12 clocks
// - during reset the program strobe pin is an input sampled for programming mode
// - external code select low means fetch from external memory starting at 0000h
package rst_strap_pkg;
  localparam int unsigned qual_periods = 64;
  localparam int unsigned drive_periods = 12;
  localparam int unsigned cnt_w = 7;
  localparam logic [cnt_w-1:0] qual_count = cnt_w'(qual_periods);
  localparam logic [cnt_w-1:0] drive_count = cnt_w'(drive_periods);
  localparam logic [cnt_w-1:0] count_zero = 7'h00;
  localparam logic [cnt_w-1:0] count_one = 7'h01;
  localparam logic [15:0] boot_vector = 16'h0000;

  typedef struct packed {
    logic in_system_programming_mode;
    logic external_fetch;
    logic [15:0] start_address;
  } boot_strap_t;

  localparam boot_strap_t strap_reset = '{1'b0, 1'b0, 16'h0000};
endpackage : rst_strap_pkg
